// ---- verilog/uart_rx_map.svh ----
// Register offsets, field positions, reset values and counts of the receiver.
// Assumes a 12-bit byte address window on an AXI4-Lite bus.
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH
`define OFF_DATA 12'h000
`define OFF_STATUS 12'h004
`define OFF_CTRL 12'h008
`define OFF_BAUD 12'h00c
`define ST_OVERRUN 3
`define ST_BREAK 2
`define ST_PARITY 1
`define ST_FRAMING 0
`define DR_FRAMING 8
`define DR_PARITY 9
`define DR_BREAK 10
`define DR_OVERRUN 11
`define CTRL_PARITY_ON 1
`define CTRL_EPS 2
`define CTRL_STP2 3
`define CTRL_FEN 4
`define CTRL_WLEN_LO 5
`define CTRL_WLEN_HI 6
`define CTRL_RESET 7'h00
`define BAUD_RESET 16'h015b
`define STATUS_RESET 4'h0
`define FIFO_DEPTH 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- verilog/uart_rx_pkg.sv ----
// Types shared by the receiver files.
// Assumes the map header supplies every number.
package uart_rx_pkg;
	typedef enum logic [2:0] {
		IDLE, START, DATA, PARITY, STOP, BRK_LOW, BRK_MARK
	} rx_state_t;
endpackage

// ---- verilog/rx_sync.sv ----
// Three-stage synchroniser for the serial receive pin.
// Assumes an asynchronous input; idle line level is high.
`timescale 1ns/10ps
module rx_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// First stage feeds only the second; level moves once two stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level <= 1'b1;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level <= s3_reg;
			end
		end
	end
endmodule

// ---- verilog/rx_fifo.sv ----
// Receive buffer: sixteen entries, or a single holding register.
// Assumes pops only when not empty and pushes only when not full.
`timescale 1ns/10ps
`include "uart_rx_map.svh"
module rx_fifo (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic one_deep,
	input wire logic flush,
	input wire logic push,
	input wire logic [10:0] push_data,
	input wire logic pop,
	output logic [10:0] head,
	output logic full,
	output logic empty,
	output logic [4:0] count
);
	logic [10:0] mem [0:`FIFO_DEPTH-1];
	logic [3:0] wr_ptr_reg;
	logic [3:0] rd_ptr_reg;
	logic [4:0] count_reg;

	assign count = count_reg;
	assign empty = (count_reg == 5'h00);
	// One-deep mode simply caps occupancy at one entry
	assign full = one_deep ? !empty : (count_reg == 5'h10);
	assign head = mem[rd_ptr_reg];

	// Storage; an entry is never written while full
	always_ff @(posedge aclk) begin
		if (push && !full) begin
			mem[wr_ptr_reg] <= push_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			wr_ptr_reg <= 4'h0;
			rd_ptr_reg <= 4'h0;
			count_reg <= 5'h00;
		end else begin
			if (push && !full) begin
				wr_ptr_reg <= wr_ptr_reg + 4'h1;
			end
			if (pop && !empty) begin
				rd_ptr_reg <= rd_ptr_reg + 4'h1;
			end
			if ((push && !full) && !(pop && !empty)) begin
				count_reg <= count_reg + 5'h01;
			end else if (!(push && !full) && (pop && !empty)) begin
				count_reg <= count_reg - 5'h01;
			end
		end
	end
endmodule

// ---- verilog/uart_rx_error_status.sv ----
// Serial receiver with error detection, status flags and AXI4-Lite slave.
// Assumes a single clock; the receive pin is asynchronous to it.
// Contract
// RULE_01: Overrun flag, bit 3, sets when a character completes with buffer full.
// RULE_02: On overrun stored characters stay intact; the new one is lost.
// RULE_03: Overrun flag holds until the clear register is written.
// RULE_04: Host drains the buffer and writes the clear register to recover.
// RULE_05: Break flag, bit 2, sets when line stays low a whole character.
// RULE_06: Each break loads exactly one zero character carrying the break mark.
// RULE_07: After break, incoming characters are ignored until break has ended.
// RULE_08: Break ends after line goes high and a valid start bit follows; here any low after the high ends it.
// RULE_09: Break flag holds until the clear register is written.
// RULE_10: Parity flag, bit 1, sets on parity mismatch with configured parity.
// RULE_11: Parity flag holds until the clear register is written.
// RULE_12: Framing flag, bit 0, sets when stop bit samples low.
// RULE_13: Framing flag holds until the clear register is written.
// RULE_14: Sixteen-deep mode ties break, parity, framing to the pushed entry.
// RULE_15: One-deep mode ties parity and framing to the holding register.
// RULE_16: Status bits 31 to 4 read as zero.
// RULE_17: Host reads status right after each data read.
// RULE_18: Any write to the status address clears all four flags.
// RULE_19: All status bits are zero after reset.
// RULE_20: Overrunning character never enters the buffer; pointers untouched.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "uart_rx_map.svh"
module uart_rx_error_status (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rxd
);
	uart_rx_pkg::rx_state_t state_reg;
	logic rx_level;
	logic [15:0] cnt_reg;
	logic [15:0] baud_reg;
	logic [6:0] ctrl_reg;
	logic [3:0] status_reg;
	logic [3:0] status_set;
	logic [3:0] bit_idx_reg;
	logic [7:0] shift_reg;
	logic zero_reg;
	logic perr_reg;
	logic ferr_reg;
	logic stop_idx_reg;
	logic tick;
	logic frame_end;
	logic is_break;
	logic framing_now;
	logic parity_now;
	logic overrun_now;
	logic fifo_push;
	logic [10:0] push_data;
	logic fifo_pop;
	logic [10:0] fifo_head;
	logic fifo_full;
	logic fifo_empty;
	logic [4:0] fifo_count;
	logic flush;
	logic [7:0] data_aligned;
	logic [3:0] nbits;
	logic [1:0] wlen;
	logic [15:0] half_bit;
	logic aw_held_reg;
	logic w_held_reg;
	logic [11:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic bvalid_next;
	logic rvalid_next;
	logic clear_status;
	logic rsel_status_reg;
	logic [31:0] rd_mux;
	logic rd_ok;

	rx_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(rxd),
		.level(rx_level)
	);

	rx_fifo u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.one_deep(!ctrl_reg[`CTRL_FEN]),
		.flush(flush),
		.push(fifo_push),
		.push_data(push_data),
		.pop(fifo_pop),
		.head(fifo_head),
		.full(fifo_full),
		.empty(fifo_empty),
		.count(fifo_count)
	);

	// Line settings decoded from the control register
	assign wlen = ctrl_reg[`CTRL_WLEN_HI:`CTRL_WLEN_LO];
	assign nbits = {2'b00, wlen} + 4'h5;
	assign half_bit = {1'b0, baud_reg[15:1]};
	assign data_aligned = shift_reg >> (2'd3 - wlen);
	assign tick = (cnt_reg == 16'h0000);

	// Frame completion and error classification
	assign frame_end = (state_reg == uart_rx_pkg::STOP) && tick &&
		(!ctrl_reg[`CTRL_STP2] || stop_idx_reg);
	assign is_break = frame_end && zero_reg && !rx_level; // [RULE_05]
	assign framing_now = frame_end && !is_break &&
		(ctrl_reg[`CTRL_STP2] ? ferr_reg : !rx_level); // [RULE_12]
	assign parity_now = frame_end && !is_break &&
		ctrl_reg[`CTRL_PARITY_ON] && perr_reg; // [RULE_10]
	assign overrun_now = frame_end && fifo_full; // [RULE_01]
	// A full buffer refuses the character outright [RULE_02] [RULE_20]
	assign fifo_push = frame_end && !fifo_full;
	// Break pushes one zero byte; errors ride with their entry
	assign push_data = is_break ? {3'b100, 8'h00} : // [RULE_06]
		{1'b0, parity_now, framing_now, data_aligned}; // [RULE_14] [RULE_15]
	assign status_set = {overrun_now, is_break, parity_now, framing_now};

	// Receive state machine; bit period is baud_reg clock cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= uart_rx_pkg::IDLE;
			cnt_reg <= 16'h0000;
			bit_idx_reg <= 4'h0;
			shift_reg <= 8'h00;
			zero_reg <= 1'b0;
			perr_reg <= 1'b0;
			ferr_reg <= 1'b0;
			stop_idx_reg <= 1'b0;
		end else begin
			if (!tick) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
			case (state_reg)
				uart_rx_pkg::IDLE: begin
					if (!rx_level) begin
						cnt_reg <= half_bit;
						state_reg <= uart_rx_pkg::START;
					end
				end
				uart_rx_pkg::START: begin
					// Glitch shorter than half a bit is rejected
					if (tick) begin
						if (!rx_level) begin
							state_reg <= uart_rx_pkg::DATA;
							cnt_reg <= baud_reg - 16'h0001;
							bit_idx_reg <= 4'h0;
							zero_reg <= 1'b1;
							stop_idx_reg <= 1'b0;
						end else begin
							state_reg <= uart_rx_pkg::IDLE;
						end
					end
				end
				uart_rx_pkg::DATA: begin
					if (tick) begin
						shift_reg <= {rx_level, shift_reg[7:1]};
						zero_reg <= zero_reg && !rx_level;
						cnt_reg <= baud_reg - 16'h0001;
						bit_idx_reg <= bit_idx_reg + 4'h1;
						if (bit_idx_reg == nbits - 4'h1) begin
							state_reg <= ctrl_reg[`CTRL_PARITY_ON] ?
								uart_rx_pkg::PARITY : uart_rx_pkg::STOP;
						end
					end
				end
				uart_rx_pkg::PARITY: begin
					if (tick) begin
						perr_reg <= (^data_aligned) ^ rx_level ^
							!ctrl_reg[`CTRL_EPS];
						zero_reg <= zero_reg && !rx_level;
						cnt_reg <= baud_reg - 16'h0001;
						state_reg <= uart_rx_pkg::STOP;
					end
				end
				uart_rx_pkg::STOP: begin
					if (tick) begin
						if (frame_end) begin
							// Break holds off reception until line marks
							state_reg <= is_break ?
								uart_rx_pkg::BRK_LOW : // [RULE_07]
								uart_rx_pkg::IDLE;
						end else begin
							ferr_reg <= !rx_level;
							zero_reg <= zero_reg && !rx_level;
							stop_idx_reg <= 1'b1;
							cnt_reg <= baud_reg - 16'h0001;
						end
					end
				end
				uart_rx_pkg::BRK_LOW: begin
					if (rx_level) begin
						state_reg <= uart_rx_pkg::BRK_MARK; // [RULE_08]
					end
				end
				uart_rx_pkg::BRK_MARK: begin
					// Next low level closes the break, whether or not the start bit proves valid
					if (!rx_level) begin
						cnt_reg <= half_bit;
						state_reg <= uart_rx_pkg::START; // [RULE_08]
					end
				end
				default: begin
					state_reg <= uart_rx_pkg::IDLE;
				end
			endcase
		end
	end

	// Sticky error flags; a set in the clearing cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= `STATUS_RESET; // [RULE_19]
		end else if (clear_status) begin
			status_reg <= status_set; // [RULE_18]
		end else begin
			// Only the clear write drops a flag [RULE_03] [RULE_09]
			status_reg <= status_reg | status_set; // [RULE_11] [RULE_13]
		end
	end

	// Write channel capture; address and data may come in either order
	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign do_write = aw_held_reg && w_held_reg && !bvalid;
	assign bvalid_next = do_write || (bvalid && !bready);
	assign clear_status = do_write && (waddr_reg == `OFF_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				waddr_reg <= awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
			// Ready returns only after the response is accepted
			awready <= !aw_take && !aw_held_reg && !bvalid_next;
			wready <= !w_take && !w_held_reg && !bvalid_next;
		end
	end

	// Write response and register updates
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			ctrl_reg <= `CTRL_RESET;
			baud_reg <= `BAUD_RESET;
			flush <= 1'b0;
		end else begin
			bvalid <= bvalid_next;
			flush <= 1'b0;
			if (do_write) begin
				bresp <= `RESP_OKAY;
				case (waddr_reg)
					`OFF_DATA, `OFF_STATUS: begin
					end
					`OFF_CTRL: begin
						if (wstrb_reg[0]) begin
							ctrl_reg <= wdata_reg[6:0];
							// Depth change would strand entries
							flush <= wdata_reg[`CTRL_FEN] !=
								ctrl_reg[`CTRL_FEN];
						end
					end
					`OFF_BAUD: begin
						if (wstrb_reg[0]) begin
							baud_reg[7:0] <= wdata_reg[7:0];
						end
						if (wstrb_reg[1]) begin
							baud_reg[15:8] <= wdata_reg[15:8];
						end
					end
					default: begin
						bresp <= `RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Read decode; data read returns byte, its own error marks and the sticky overrun flag
	always_comb begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		case (araddr)
			`OFF_DATA: begin
				if (!fifo_empty) begin
					rd_mux[10:0] = fifo_head;
				end
				rd_mux[`DR_OVERRUN] = status_reg[`ST_OVERRUN];
			end
			`OFF_STATUS: begin
				rd_mux[3:0] = status_reg; // [RULE_16]
			end
			`OFF_CTRL: begin
				rd_mux[6:0] = ctrl_reg;
			end
			`OFF_BAUD: begin
				rd_mux[15:0] = baud_reg;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	assign ar_take = arvalid && arready;
	assign rvalid_next = ar_take || (rvalid && !rready);
	// Reading the data word removes the oldest entry
	assign fifo_pop = ar_take && (araddr == `OFF_DATA) && !fifo_empty;

	// Read channel; answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
			rsel_status_reg <= 1'b0;
		end else begin
			arready <= !rvalid_next;
			rvalid <= rvalid_next;
			if (ar_take) begin
				rdata <= rd_mux;
				rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
				rsel_status_reg <= (araddr == `OFF_STATUS);
			end
		end
	end

	a_overrun_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		overrun_now |=> status_reg[`ST_OVERRUN]) // [RULE_01]
		else $error("overrun flag missing");
	a_overrun_no_store: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(overrun_now && !fifo_pop && !flush) |=>
		fifo_count == $past(fifo_count)) // [RULE_02] [RULE_20]
		else $error("overrun changed buffer");
	a_flags_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		!clear_status |=> (status_reg & $past(status_reg)) ==
		$past(status_reg)) // [RULE_03] [RULE_09] [RULE_11] [RULE_13]
		else $error("flag dropped without clear");
	a_break_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		is_break |=> status_reg[`ST_BREAK] &&
		state_reg == uart_rx_pkg::BRK_LOW) // [RULE_05]
		else $error("break not flagged");
	a_break_zero_char: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(is_break && !fifo_full) |-> fifo_push &&
		push_data == 11'h400) // [RULE_06] [RULE_14]
		else $error("break char wrong");
	a_break_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == uart_rx_pkg::BRK_LOW ||
		state_reg == uart_rx_pkg::BRK_MARK) |-> !fifo_push) // [RULE_07]
		else $error("char stored during break");
	a_break_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == uart_rx_pkg::BRK_LOW) ##1
		(state_reg != uart_rx_pkg::BRK_LOW) |->
		state_reg == uart_rx_pkg::BRK_MARK && $past(rx_level)) // [RULE_08]
		else $error("break left without marking");
	a_parity_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		parity_now |=> status_reg[`ST_PARITY]) // [RULE_10]
		else $error("parity flag missing");
	a_framing_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		framing_now |=> status_reg[`ST_FRAMING]) // [RULE_12]
		else $error("framing flag missing");
	a_clear_all: assert property (@(posedge aclk) disable iff (!aresetn)
		(clear_status && status_set == 4'h0) |=>
		status_reg == 4'h0) // [RULE_18]
		else $error("clear left a flag");
	a_reserved_zero: assert property (@(posedge aclk) // [RULE_16]
		disable iff (!aresetn)
		(rvalid && rsel_status_reg) |-> rdata[31:4] == 28'h0000000)
		else $error("reserved status bits set");
	a_reset_clears: assert property (@(posedge aclk)
		!aresetn |=> status_reg == 4'h0) // [RULE_19]
		else $error("status not cleared by reset");
endmodule

// ---- verification/serial_sender.sv ----
// Behavioural remote sender that drives the serial receive line.
// Assumes the bench clock; one bit lasts BIT_CYC clock cycles.
`timescale 1ns/10ps
module serial_sender #(
	parameter int BIT_CYC = 8
) (
	input wire logic aclk,
	output logic rxd
);
	// Line idles marking between frames
	initial rxd = 1'b1;

	// One bit time at a level, changed just after an edge
	task automatic put(input logic v);
		rxd <= v;
		repeat (BIT_CYC) @(posedge aclk);
	endtask

	// Start, eight data bits LSB first, parity, stop, two idle bits
	task automatic send(input logic [7:0] d, input logic par,
			input logic stop);
		put(1'b0);
		for (int i = 0; i < 8; i++) put(d[i]);
		put(par);
		put(stop);
		put(1'b1);
		put(1'b1);
	endtask

	// Spacing far longer than a character, then marking again
	task automatic hold_low(input int n);
		repeat (n) put(1'b0);
		put(1'b1);
		put(1'b1);
	endtask
endmodule

// ---- verification/uart_rx_error_status_bench.sv ----
// Self-checking bench: AXI4-Lite master tasks plus a serial sender.
// Assumes the design map header and a 40 MHz clock.
`timescale 1ns/10ps
`include "uart_rx_map.svh"
module uart_rx_error_status_bench;
	logic aclk, aresetn, rxd;
	logic [11:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] b;
	int fail_count, n_compared;

	uart_rx_error_status dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.rxd(rxd));
	serial_sender #(.BIT_CYC(8)) tx (.aclk(aclk), .rxd(rxd));

	// Free-running bench clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic final_report();
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
			input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Write: address and data offered together, bready held until bvalid
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 200) begin
			fail_count++;
			final_report();
		end
		rsp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Read: rready held until rvalid is sampled
	task automatic rd(input logic [11:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 200) begin
			fail_count++;
			final_report();
		end
		v = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e,
			input string nm);
		rd(a);
		chk(nm, v, e);
	endtask

	// Main sequence: reset, then one scenario per error kind, then parity and overrun again on the one-deep buffer
	initial begin
		aresetn = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b0;
		rready = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		fail_count = 0;
		n_compared = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(`OFF_STATUS, 32'h0, "status_reset");
		rd(12'h010);
		chk("unmapped_read", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
		wr(12'h010, 32'h0);
		chk("unmapped_write", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
		wr(`OFF_BAUD, 32'h8);
		// Eight bits, even parity, sixteen-deep buffer
		wr(`OFF_CTRL, 32'h76);
		tx.send(8'ha5, ^8'ha5, 1'b1);
		rdc(`OFF_DATA, 32'h0a5, "data_clean");
		rdc(`OFF_STATUS, 32'h0, "status_clean");
		// Bad parity followed by a clean character
		tx.send(8'h3c, 1'b1, 1'b1);
		tx.send(8'h11, ^8'h11, 1'b1);
		rdc(`OFF_DATA, 32'h23c, "data_parity");
		rdc(`OFF_STATUS, 32'h2, "status_parity");
		rdc(`OFF_DATA, 32'h011, "data_after");
		rdc(`OFF_STATUS, 32'h2, "parity_held");
		wr(`OFF_STATUS, 32'h0);
		rdc(`OFF_STATUS, 32'h0, "clear_zero");
		// Stop bit low on a non-zero character
		tx.send(8'h5a, ^8'h5a, 1'b0);
		rdc(`OFF_DATA, 32'h15a, "data_framing");
		rdc(`OFF_STATUS, 32'h1, "framing_held");
		wr(`OFF_STATUS, 32'h5);
		rdc(`OFF_STATUS, 32'h0, "clear_any");
		// Long spacing, marking, then a frame that ends the break
		tx.hold_low(25);
		tx.send(8'h11, ^8'h11, 1'b1);
		rdc(`OFF_DATA, 32'h400, "data_break");
		rdc(`OFF_STATUS, 32'h4, "status_break");
		rdc(`OFF_DATA, 32'h011, "after_break");
		rdc(`OFF_DATA, 32'h0, "one_null");
		rdc(`OFF_STATUS, 32'h4, "break_held");
		wr(`OFF_STATUS, 32'h0);
		rdc(`OFF_STATUS, 32'h0, "break_clear");
		// Seventeen characters into sixteen places
		for (int i = 0; i < 17; i++) begin
			b = 8'h40 + 8'(i);
			tx.send(b, ^b, 1'b1);
		end
		rdc(`OFF_STATUS, 32'h8, "status_over");
		for (int i = 0; i < 16; i++) begin
			b = 8'h40 + 8'(i);
			rdc(`OFF_DATA, {20'h0, 4'h8, b}, "data_kept");
		end
		rdc(`OFF_DATA, 32'h800, "lost_char");
		rdc(`OFF_STATUS, 32'h8, "over_held");
		wr(`OFF_STATUS, 32'h0);
		rdc(`OFF_STATUS, 32'h0, "over_clear");
		// One-deep holding register: bad parity, then a lost char
		wr(`OFF_CTRL, 32'h66);
		tx.send(8'h01, 1'b0, 1'b1);
		tx.send(8'h02, ^8'h02, 1'b1);
		rdc(`OFF_STATUS, 32'ha, "status_single");
		rdc(`OFF_DATA, 32'ha01, "data_single");
		rdc(`OFF_DATA, 32'h800, "single_lost");
		wr(`OFF_STATUS, 32'h0);
		rdc(`OFF_STATUS, 32'h0, "single_clear");
		final_report();
	end
endmodule
